/* File: pkg/twcam_pkg.sv */
// twcam_pkg: constants and carriers for the two-wire config, address match and recovery block
// assumes a byte-wide plain register port and a 200 MHz system clock
`default_nettype none
package twcam_pkg;
  // register offsets (byte index on the plain port)
  localparam logic [2:0] OFF_ENABLE_CLOCK_RATE = 3'h0;
  localparam logic [2:0] OFF_OWN_SLAVE_ID = 3'h1;
  localparam logic [2:0] OFF_TRANSFER_CTRL = 3'h2;
  localparam logic [2:0] OFF_MAIN_STATUS = 3'h3;
  localparam logic [2:0] OFF_LINE_STATUS = 3'h4;
  // enable_and_clock_rate fields
  localparam int ENABLE_BIT = 0;
  localparam int FREQ_LSB = 1;
  localparam logic [7:0] ENABLE_CLOCK_RATE_RESET = 8'h00;
  // own_slave_identity fields
  localparam int SLAVE_MATCH_ENABLE_BIT = 7;
  // transfer_control_reg fields
  localparam int START_BIT = 0;
  localparam int STOP_BIT = 1;
  // main_status_reg fields
  localparam int MASTER_BIT = 1;
  // line_status_reg fields
  localparam int BUSY_BIT = 0;
  localparam int BUS_ACTIVITY_BIT = 1;
  localparam int MATCH_BIT = 2;
  localparam int DATA_SENSE_BIT = 4;
  localparam int CLOCK_PULSE_BIT = 5;
  // minimum legal clock half period field value
  localparam logic [6:0] FREQ_MIN = 7'h08;

  // synchronised bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } twcam_lines_s;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } twcam_req_s;
endpackage : twcam_pkg
`default_nettype wire

/* File: core/twcam_sync.sv */
// twcam_sync: two flip-flop synchroniser for bus line inputs
// assumes inputs come from pins outside the sys_clk domain
`default_nettype none
module twcam_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= IDLE;
      synced <= IDLE;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule : twcam_sync
`default_nettype wire

/* File: core/twcam_core.sv */
// twcam_core: enable/clock rate, own-address match, bus-busy tracking, SDA recovery
// assumes open-drain SDA/SCL with external pull-ups; oe low means pin driven low
//
// Implementation choices: the plain strobed port and the address map.
`default_nettype none
module twcam_core
  import twcam_pkg::*;
#(
  parameter int IDLE_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire twcam_req_s req,
  output logic [7:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [IDLE_WIDTH-1:0] idle_count
);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_HOLD} twcam_mst_e;
  twcam_lines_s lines;
  twcam_lines_s prevLines;
  logic [7:0] enableClockRate;
  logic [7:0] ownSlaveIdentity;
  logic [7:0] transferControl;
  logic masterFlag;
  logic busActivity;
  logic matchFlag;
  logic addrBusy;
  logic clockPulseReq;
  logic pulseHigh;
  logic [7:0] halfCount;
  logic [3:0] bitCount;
  logic [6:0] shiftAddr;
  logic enabled;
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic halfDone;
  logic wrBusy;
  logic sclDriveLow;
  logic sdaDriveLow;
  logic [7:0] halfPeriod;
  twcam_mst_e mstState;

  assign enabled = enableClockRate[ENABLE_BIT];
  // half period in cycles: 2 * field value
  assign halfPeriod = {enableClockRate[7:FREQ_LSB], 1'b0};
  assign halfDone = (halfCount >= halfPeriod - 8'h01);
  assign wrBusy = req.wr && req.addr == OFF_LINE_STATUS && req.wdata[BUS_ACTIVITY_BIT];

  // synchronise both bus lines
  twcam_sync #(.WIDTH(2), .IDLE(2'b11)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async({scl_in, sda_in}),
    .synced(lines)
  );

  // line edge and condition detection on synchronised levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevLines <= '1;
    end else begin
      prevLines <= lines;
    end
  end
  assign startCond = enabled && lines.scl && prevLines.scl && prevLines.sda && !lines.sda;
  assign stopCond = enabled && lines.scl && prevLines.scl && !prevLines.sda && lines.sda;
  assign sclRise = lines.scl && !prevLines.scl;

  // enable and clock rate register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enableClockRate <= ENABLE_CLOCK_RATE_RESET;
    end else if (req.wr && req.addr == OFF_ENABLE_CLOCK_RATE) begin
      enableClockRate <= req.wdata;
    end
  end

  // own identity register, intentionally without reset
  always_ff @(posedge sys_clk) begin
    if (req.wr && req.addr == OFF_OWN_SLAVE_ID) begin
      ownSlaveIdentity <= req.wdata;
    end
  end

  // transfer control: start request held until start is sent
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transferControl <= 8'h00;
    end else if (!enabled) begin
      transferControl <= 8'h00;
    end else if (req.wr && req.addr == OFF_TRANSFER_CTRL) begin
      transferControl <= req.wdata;
    end else if (mstState == ST_START && halfDone) begin
      transferControl[START_BIT] <= 1'b0;
    end else if (transferControl[STOP_BIT] && masterFlag && stopCond) begin
      transferControl[STOP_BIT] <= 1'b0;
    end
  end

  // bus activity flag: set wins over software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busActivity <= 1'b0;
    end else if (!enabled) begin
      busActivity <= 1'b0;
    end else if (startCond || !lines.sda || !lines.scl) begin
      busActivity <= 1'b1;
    end else if (stopCond || wrBusy) begin
      busActivity <= 1'b0;
    end
  end

  // idle time counter while the flag stays set and lines are high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_count <= '0;
    end else if (!busActivity || !lines.sda || !lines.scl) begin
      idle_count <= '0;
    end else if (idle_count != '1) begin
      idle_count <= idle_count + 1'b1;
    end
  end

  // master sequencer: start generation and master hold until stop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mstState <= ST_IDLE;
      masterFlag <= 1'b0;
    end else if (!enabled) begin
      mstState <= ST_IDLE;
      masterFlag <= 1'b0;
    end else begin
      case (mstState)
        ST_IDLE: begin
          if (transferControl[START_BIT] && !masterFlag && !busActivity) begin
            mstState <= ST_START;
          end
        end
        ST_START: begin
          if (halfDone) begin
            mstState <= ST_HOLD;
            masterFlag <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (transferControl[STOP_BIT] && stopCond) begin
            mstState <= ST_IDLE;
            masterFlag <= 1'b0;
          end
        end
        default: begin
          mstState <= ST_IDLE;
        end
      endcase
    end
  end

  // clock pulse request: accepted only while SDA is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clockPulseReq <= 1'b0;
      pulseHigh <= 1'b0;
    end else if (!enabled) begin
      clockPulseReq <= 1'b0;
      pulseHigh <= 1'b0;
    end else if (!clockPulseReq) begin
      if (req.wr && req.addr == OFF_LINE_STATUS && req.wdata[CLOCK_PULSE_BIT] && !lines.sda) begin
        clockPulseReq <= 1'b1;
      end
    end else if (halfDone && pulseHigh) begin
      clockPulseReq <= 1'b0;
      pulseHigh <= 1'b0;
    end else if (halfDone) begin
      pulseHigh <= 1'b1;
    end
  end

  // half period timer shared by start generation and clock pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCount <= 8'h00;
    end else if ((mstState == ST_START || clockPulseReq) && !halfDone) begin
      halfCount <= halfCount + 8'h01;
    end else begin
      halfCount <= 8'h00;
    end
  end

  // slave address capture and compare
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCount <= 4'h0;
      shiftAddr <= 7'h00;
      matchFlag <= 1'b0;
      addrBusy <= 1'b0;
    end else if (!enabled || stopCond) begin
      bitCount <= 4'h0;
      matchFlag <= 1'b0;
      addrBusy <= 1'b0;
    end else if (startCond) begin
      bitCount <= 4'h0;
      matchFlag <= 1'b0;
      addrBusy <= !masterFlag;
    end else if (addrBusy && sclRise) begin
      if (bitCount < 4'h7) begin
        shiftAddr <= {shiftAddr[5:0], lines.sda};
        bitCount <= bitCount + 4'h1;
      end
      if (bitCount == 4'h7) begin
        addrBusy <= 1'b0;
        matchFlag <= ownSlaveIdentity[SLAVE_MATCH_ENABLE_BIT]
          && shiftAddr == ownSlaveIdentity[6:0];
      end
    end
  end

  // open-drain drive: start pulls SDA, pulse pulls SCL during its low half
  assign sdaDriveLow = (mstState == ST_START) || (mstState == ST_HOLD && !clockPulseReq);
  assign sclDriveLow = (clockPulseReq && !pulseHigh);
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = !(enabled && sdaDriveLow && !transferControl[STOP_BIT]);
  assign scl_oe = !(enabled && sclDriveLow);

  // register read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        OFF_ENABLE_CLOCK_RATE: rdata <= enableClockRate;
        OFF_OWN_SLAVE_ID: rdata <= ownSlaveIdentity;
        OFF_TRANSFER_CTRL: rdata <= transferControl;
        OFF_MAIN_STATUS: rdata <= {6'h00, masterFlag, 1'b0};
        OFF_LINE_STATUS: rdata <= {2'b00, clockPulseReq, lines.sda, 1'b0, matchFlag,
          busActivity, addrBusy || masterFlag || mstState == ST_START};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // disabling clears the status that software sees
  a_disable_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enabled |=> !busActivity && !masterFlag && transferControl == 8'h00)
    else $error("disable left status set");

  a_reset_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> enableClockRate == 8'h00)
    else $error("enable register not cleared by reset");

  a_start_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mstState == ST_IDLE && busActivity |=> mstState != ST_START)
    else $error("start issued while bus busy");

  a_start_go: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enabled && mstState == ST_IDLE && transferControl[START_BIT] && !masterFlag
      && !busActivity |=> mstState == ST_START)
    else $error("pending start not executed");

  sequence s_start_phase;
    mstState == ST_START ##1 mstState == ST_START;
  endsequence
  a_master_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_start_phase |-> ##[0:260] masterFlag)
    else $error("master flag not set after start");

  a_no_match_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ownSlaveIdentity[SLAVE_MATCH_ENABLE_BIT] && $stable(ownSlaveIdentity) |=> !$rose(matchFlag))
    else $error("match declared with compare disabled");

  a_pulse_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clockPulseReq && lines.sda |=> !clockPulseReq)
    else $error("pulse accepted with SDA high");

  a_stop_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stopCond && !startCond |=> !busActivity)
    else $error("stop did not clear bus activity");

  a_busy_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enabled && startCond |=> busActivity)
    else $error("start did not set bus activity");
endmodule : twcam_core
`default_nettype wire

/* File: verification/twcam_bus_peer.sv */
// twcam_bus_peer: another master and an out-of-step slave on the two-wire bus
// assumes the bench resolves the wired-and lines with pull-ups
`default_nettype none
module twcam_bus_peer (
  input wire logic scl,
  output var logic sclDrvN,
  output var logic sdaDrvN
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 80; // half of the 160 ns link clock
  // both lines released while idle; the clock stands still between frames
  initial begin
    sclDrvN = 1'b1;
    sdaDrvN = 1'b1;
  end
  // start: data falls while the clock is high
  task automatic start_cond();
    sdaDrvN = 1'b0;
    #HALF;
  endtask : start_cond
  // address bits msb first, then a read bit that leaves data high; ends with the clock high
  task automatic send_bits(input logic [6:0] a);
    logic [7:0] frame;
    frame = {a, 1'b1};
    for (int i = 7; i >= 0; i--) begin
      sclDrvN = 1'b0;
      #(HALF / 2) sdaDrvN = frame[i];
      #(HALF / 2) sclDrvN = 1'b1;
      #HALF;
    end
  endtask : send_bits
  // stop: data rises while the clock is high
  task automatic stop_cond();
    sclDrvN = 1'b0;
    #(HALF / 2) sdaDrvN = 1'b0;
    #(HALF / 2) sclDrvN = 1'b1;
    #HALF sdaDrvN = 1'b1;
    #HALF;
  endtask : stop_cond
  // a slave out of step holds data low until the clock has fallen n times, releasing it on the n-th falling edge
  task automatic stick_data(input int n);
    sdaDrvN = 1'b0;
    repeat (n) @(negedge scl);
    sdaDrvN = 1'b1;
  endtask : stick_data
endmodule : twcam_bus_peer
`default_nettype wire

/* File: verification/tb_twcam_core.sv */
// tb_twcam_core: self-checking bench for config, address match and recovery
// assumes open-drain lines with pull-ups and the peer model on the far side
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_twcam_core
  import twcam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, sclOe, sdaOe, sclDrvN, sdaDrvN, sdaLowSeen, sclWire, sdaWire;
  twcam_req_s req;
  logic [7:0] rdata;
  logic [15:0] idleCount;
  int fail_count = 0;
  int check_count = 0;
  // wired-and lines, pulled up when nobody drives
  assign sclWire = sclOe & sclDrvN;
  assign sdaWire = sdaOe & sdaDrvN;
  twcam_core #(.IDLE_WIDTH(16)) i_twcam_core (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .scl_in(sclWire), .scl_out(), .scl_oe(sclOe), .sda_in(sdaWire),
    .sda_out(), .sda_oe(sdaOe), .idle_count(idleCount));
  twcam_bus_peer i_twcam_bus_peer (.scl(sclWire), .sclDrvN(sclDrvN), .sdaDrvN(sdaDrvN));
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // remembers that the block pulled data low
  always @(posedge sys_clk) if (sdaOe === 1'b0) sdaLowSeen <= 1'b1;
  // hang guard
  initial begin
    #400us;
    expire();
  end
  function automatic logic [7:0] cfg_byte(input logic [6:0] half, input logic en);
    return {half, en};
  endfunction : cfg_byte
  function automatic logic exp_match(input logic [7:0] id, input logic [6:0] rx);
    return id[SLAVE_MATCH_ENABLE_BIT] && (id[6:0] == rx);
  endfunction : exp_match
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic expire();
    fail_count++;
    $display("MISMATCH at %0t: wait ran out", $time);
    stop_test();
  endtask : expire
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic count_low(input int n, inout int c);
    repeat (n) begin
      @(posedge sys_clk);
      if (sclOe !== 1'b1) c++;
    end
  endtask : count_low
  // one requested clock pulse: low and high each 2*f cycles, then self-clear
  task automatic pulse_once(input int f);
    int k, c, lowCnt;
    logic [7:0] d;
    lowCnt = 0;
    c = 0;
    wr(OFF_LINE_STATUS, 8'h20);
    for (k = 0; k < 50 && sclOe !== 1'b0; k++) @(posedge sys_clk);
    if (k == 50) expire();
    while (sclOe === 1'b0 && lowCnt < 300) begin
      @(posedge sys_clk);
      lowCnt++;
    end
    `CHK(lowCnt, 2 * f)
    count_low(2 * f - 4, c);
    rd(OFF_LINE_STATUS, d);
    `CHK(d[CLOCK_PULSE_BIT], 1'b1)
    count_low(6, c);
    rd(OFF_LINE_STATUS, d);
    `CHK(d[CLOCK_PULSE_BIT], 1'b0)
    count_low(2 * f, c);
    `CHK(c, 0)
  endtask : pulse_once
  // main sequence
  initial begin
    int f, k, c;
    logic [6:0] own, rx;
    logic [7:0] d, id;
    req = '0;
    rst_n = 1'b0;
    sdaLowSeen = 1'b0;
    void'($urandom(94));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    `CHK(sclOe, 1'b1)
    `CHK(idleCount, 16'h0000)
    rd(OFF_ENABLE_CLOCK_RATE, d);
    `CHK(d, ENABLE_CLOCK_RATE_RESET)
    $display("test reset done");
    // random fields read back; unmapped places read zero
    for (k = 0; k < 6; k++) begin
      d = cfg_byte(7'(8 + $urandom_range(0, 119)), 1'b1);
      wr(OFF_ENABLE_CLOCK_RATE, d);
      rd(OFF_ENABLE_CLOCK_RATE, id);
      `CHK(id, d)
      d = 8'($urandom);
      wr(OFF_OWN_SLAVE_ID, d);
      rd(OFF_OWN_SLAVE_ID, id);
      `CHK(id, d)
      rd(3'(5 + k % 3), id);
      `CHK(id, 8'h00)
    end
    wr(OFF_LINE_STATUS, 8'h00);
    rd(OFF_LINE_STATUS, d);
    `CHK(d[DATA_SENSE_BIT], sdaWire)
    `CHK(d[BUS_ACTIVITY_BIT], 1'b0)
    $display("test registers done");
    // frames: match, mismatch, match with comparison off
    own = 7'($urandom) | 7'h01;
    for (k = 0; k < 3; k++) begin
      id = {k != 2, own};
      rx = (k == 1) ? own ^ 7'($urandom_range(1, 127)) : own;
      wr(OFF_OWN_SLAVE_ID, id);
      i_twcam_bus_peer.start_cond();
      i_twcam_bus_peer.send_bits(rx);
      wait_cycles(30);
      rd(OFF_LINE_STATUS, d);
      `CHK(d[BUSY_BIT], 1'b0)
      `CHK(d[MATCH_BIT], exp_match(id, rx))
      `CHK(d[BUS_ACTIVITY_BIT], 1'b1)
      if (k == 0) `CHK(idleCount != 16'h0000, 1'b1)
      i_twcam_bus_peer.stop_cond();
      wait_cycles(10);
      rd(OFF_LINE_STATUS, d);
      `CHK(d[2:1], 2'b00)
    end
    $display("test address done");
    // start held off by a busy bus, then dropped by disabling
    i_twcam_bus_peer.start_cond();
    wr(OFF_TRANSFER_CTRL, 8'h01);
    wait_cycles(40);
    rd(OFF_MAIN_STATUS, d);
    `CHK(d[MASTER_BIT], 1'b0)
    wr(OFF_ENABLE_CLOCK_RATE, cfg_byte(7'h08, 1'b0));
    rd(OFF_TRANSFER_CTRL, d);
    `CHK(d, 8'h00)
    rd(OFF_LINE_STATUS, d);
    `CHK(d & 8'h07, 8'h00)
    i_twcam_bus_peer.stop_cond();
    $display("test disable done");
    // recovery of a data line held low by a slave
    f = 8 + $urandom_range(0, 7);
    fork
      i_twcam_bus_peer.stick_data(2);
    join_none
    wr(OFF_ENABLE_CLOCK_RATE, 8'h00);
    wr(OFF_ENABLE_CLOCK_RATE, cfg_byte(7'(f), 1'b1));
    wr(OFF_TRANSFER_CTRL, 8'h01);
    sdaLowSeen = 1'b0;
    wait_cycles(4 * f);
    rd(OFF_MAIN_STATUS, d);
    `CHK(d[MASTER_BIT] | sdaLowSeen, 1'b0)
    rd(OFF_LINE_STATUS, d);
    `CHK(d[DATA_SENSE_BIT:BUS_ACTIVITY_BIT], 4'b0001)
    for (k = 0; k < 4; k++) begin
      rd(OFF_LINE_STATUS, d);
      if (d[DATA_SENSE_BIT] === 1'b1) break;
      pulse_once(f);
    end
    `CHK(k, 2)
    c = 0;
    wr(OFF_LINE_STATUS, 8'h20);
    count_low(4 * f + 8, c);
    `CHK(c, 0)
    wr(OFF_LINE_STATUS, 8'h02);
    for (k = 0; k < 100; k++) begin
      rd(OFF_MAIN_STATUS, d);
      if (d[MASTER_BIT] === 1'b1) break;
    end
    if (k == 100) expire();
    `CHK(sdaLowSeen, 1'b1)
    $display("test recovery done");
    stop_test();
  end
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cycles
endmodule : tb_twcam_core
`default_nettype wire
